/* File: rtl/avio_port.sv */
// Avionics serial port: two receivers, one transmitter with word FIFO,
// and a 16-bit parallel host bus moving each word as two halves.
// Assumes host pins are asynchronous to clock and are synchronised here.
`timescale 1ns/1ns
`include "avio_defines.svh"
module avio_port #(
  parameter int MASTER_DIV = `CLOCK_KHZ / `MASTER_KHZ,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial line inputs, bit 1 one level, bit 0 zero level
  input wire logic [1:0] rx_one_line_in,
  input wire logic [1:0] rx_two_line_in,
  // Parallel data bus
  input wire avio_pkg::half_t parallel_bus_bit_in,
  output avio_pkg::half_t parallel_bus_bit_out,
  output logic parallel_bus_bit_oe,
  // Receiver host controls
  input wire logic half_word_chooser,
  input wire logic rx_one_bus_drive,
  input wire logic rx_two_bus_drive,
  output logic rx_one_ready_n,
  output logic rx_two_ready_n,
  // Transmitter and control host controls
  input wire logic tx_low_half_latch,
  input wire logic tx_high_half_latch,
  input wire logic config_word_strobe,
  input wire logic xmit_go,
  input wire logic bit_control_gate_n,
  output logic xmit_ready_flag,
  // Serial line outputs
  output logic ones_line_out,
  output logic zeros_line_out,
  output logic tx_clock_out
);
  import avio_pkg::*;
  localparam int MW = $clog2(MASTER_DIV + 1);
  localparam int PW = $clog2(FIFO_DEPTH);

  // Elaboration check on parameters
  if (MASTER_DIV < 1 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : bad_cfg
    $error("avio_port: MASTER_DIV below 1 or FIFO_DEPTH not a power of two");
  end

  // Pin synchroniser, two flops for every outside input
  logic [27:0] pins_raw;
  logic [27:0] sync_a;
  logic [27:0] sync_b;
  half_t bus_s;
  logic sel_s;
  logic en1_s;
  logic en2_s;
  logic low_s;
  logic high_s;
  logic cws_s;
  logic go_s;
  logic gate_n_s;
  logic [1:0] line1_s;
  logic [1:0] line2_s;
  assign pins_raw = {parallel_bus_bit_in, half_word_chooser, rx_one_bus_drive,
                     rx_two_bus_drive, tx_low_half_latch, tx_high_half_latch,
                     config_word_strobe, xmit_go, bit_control_gate_n,
                     rx_one_line_in, rx_two_line_in};
  assign {bus_s, sel_s, en1_s, en2_s, low_s, high_s, cws_s, go_s, gate_n_s,
          line1_s, line2_s} = sync_b;

  // Open gate pin reads as high from reset onward
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_a <= `SYNC_RESET;
      sync_b <= `SYNC_RESET;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  // Delayed copies for edge detection on host strobes
  logic en1_d;
  logic en2_d;
  logic sel_d;
  logic low_d;
  logic high_d;
  logic cws_d;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en1_d <= 1'b1;
      en2_d <= 1'b1;
      sel_d <= 1'b0;
      low_d <= 1'b0;
      high_d <= 1'b0;
      cws_d <= 1'b0;
    end else begin
      en1_d <= en1_s;
      en2_d <= en2_s;
      sel_d <= sel_s;
      low_d <= low_s;
      high_d <= high_s;
      cws_d <= cws_s;
    end
  end
  wire low_rise = low_s & ~low_d;
  wire high_rise = high_s & ~high_d;
  wire cws_rise = cws_s & ~cws_d;

  // Control word, eleven live bits
  half_t ctrl;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
    end else if (cws_rise) begin
      ctrl <= bus_s & `CTRL_MASK;
    end
  end
  wire par_en = ctrl[`CTRL_PAR_EN];
  wire self_test = ~ctrl[`CTRL_SELF_TEST_N];
  wire par_even = ctrl[`CTRL_PAR_EVEN];
  wire tx_slow = ctrl[`CTRL_TX_SLOW];
  wire rx_slow = ctrl[`CTRL_RX_SLOW];

  // Master tick at the nominal 1 MHz from the fast clock
  logic [MW-1:0] mcount;
  wire master_tick = mcount == MW'(MASTER_DIV - 1);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mcount <= '0;
    end else begin
      mcount <= master_tick ? '0 : mcount + MW'(1);
    end
  end

  // Receive sample tick, every master tick or every eighth
  logic [2:0] rx_pre;
  wire rx_pre_last = rx_pre == 3'(`RX_SLOW_DIV - 1);
  wire sample_tick = master_tick & (~rx_slow | rx_pre_last);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_pre <= 3'h0;
    end else if (master_tick) begin
      rx_pre <= rx_pre_last ? 3'h0 : rx_pre + 3'h1;
    end
  end

  // Transmit bit divider; a change of rate takes effect at once
  logic [6:0] tx_div;
  logic [6:0] tx_limit;
  assign tx_limit = tx_slow ? 7'(`TX_SLOW_DIV) : 7'(`TX_FAST_DIV);
  wire bit_tick = master_tick && tx_div >= tx_limit - 7'h01;
  wire tx_first_half = tx_div < (tx_limit >> 1);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_div <= 7'h00;
      tx_clock_out <= 1'b0;
    end else begin
      if (master_tick) begin
        tx_div <= bit_tick ? 7'h00 : tx_div + 7'h01;
      end
      tx_clock_out <= tx_first_half;
    end
  end

  // Receivers, fed from the transmitter outputs in self test
  word_t rx1_word;
  word_t rx2_word;
  logic [1:0] line1_in;
  logic [1:0] line2_in;
  assign line1_in = self_test ? {ones_line_out, zeros_line_out} : line1_s;
  assign line2_in = self_test ? {ones_line_out, zeros_line_out} : line2_s;

  // Read windows; receiver one wins when both enables are low
  wire rd1 = ~en1_s;
  wire rd2 = ~en2_s & en1_s;
  wire rd1_end = en1_s & ~en1_d;
  wire rd2_end = en2_s & ~en2_d & en1_d;
  wire low_done1 = rd1_end & ~sel_d;
  wire high_done1 = rd1_end & sel_d;
  wire low_done2 = rd2_end & ~sel_d;
  wire high_done2 = rd2_end & sel_d;

  avio_receiver u_rx_one (
    .clock(clock),
    .rstn(rstn),
    .sample_tick(sample_tick),
    .line_one(line1_in[1]),
    .line_zero(line1_in[0]),
    .decoder_on(ctrl[`CTRL_DEC1_EN]),
    .match_b9(ctrl[`CTRL_DEC1_B9]),
    .match_b10(ctrl[`CTRL_DEC1_B10]),
    .read_low_done(low_done1),
    .read_high_done(high_done1),
    .word(rx1_word),
    .ready_n(rx_one_ready_n)
  );

  avio_receiver u_rx_two (
    .clock(clock),
    .rstn(rstn),
    .sample_tick(sample_tick),
    .line_one(line2_in[1]),
    .line_zero(line2_in[0]),
    .decoder_on(ctrl[`CTRL_DEC2_EN]),
    .match_b9(ctrl[`CTRL_DEC2_B9]),
    .match_b10(ctrl[`CTRL_DEC2_B10]),
    .read_low_done(low_done2),
    .read_high_done(high_done2),
    .word(rx2_word),
    .ready_n(rx_two_ready_n)
  );

  // Low byte of the first half carries serial bits 1..8 reversed
  half_t low_stage;
  logic [7:0] rev1;
  logic [7:0] rev2;
  logic [7:0] rev_tx;
  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign rev1[i] = rx1_word[7 - i];
    assign rev2[i] = rx2_word[7 - i];
    assign rev_tx[i] = low_stage[7 - i];
  end

  // Half-word selection for reads
  half_t rx1_half;
  half_t rx2_half;
  assign rx1_half = sel_s ? rx1_word[28:13] :
                    {rx1_word[12:8], rx1_word[30], rx1_word[29], rx1_word[31], rev1};
  assign rx2_half = sel_s ? rx2_word[28:13] :
                    {rx2_word[12:8], rx2_word[30], rx2_word[29], rx2_word[31], rev2};

  // Bus driver, registered; released outside reads
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      parallel_bus_bit_out <= '0;
      parallel_bus_bit_oe <= 1'b0;
    end else begin
      parallel_bus_bit_out <= rd1 ? rx1_half : (rd2 ? rx2_half : '0);
      parallel_bus_bit_oe <= rd1 | rd2;
    end
  end

  // Transmit halves; a high latch with no low latch before it is ignored
  logic low_seen;
  wire push_try = high_rise & low_seen;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_stage <= '0;
      low_seen <= 1'b0;
    end else if (low_rise) begin
      low_stage <= bus_s;
      low_seen <= 1'b1;
    end else if (push_try) begin
      low_seen <= 1'b0;
    end
  end

  // Word assembly and parity insertion at load time
  word_t tx_raw;
  word_t tx_word;
  assign tx_raw = {low_stage[8], low_stage[10], low_stage[9], bus_s,
                   low_stage[15:11], rev_tx};
  wire par_on = par_en & gate_n_s;
  wire par_calc = par_even ? ^tx_raw[30:0] : ~^tx_raw[30:0];
  assign tx_word = {par_on ? par_calc : tx_raw[31], tx_raw[30:0]};

  // Transmit FIFO; a load into a full FIFO is dropped
  word_t fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  logic tx_load;
  wire fifo_full = fill == (PW + 1)'(FIFO_DEPTH);
  wire fifo_empty = fill == '0;
  wire push = push_try & ~fifo_full;
  always_ff @(posedge clock) begin
    if (push) begin
      fifo_mem[wr_ptr] <= tx_word;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (tx_load) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      if (push & ~tx_load) begin
        fill <= fill + (PW + 1)'(1);
      end else if (tx_load & ~push) begin
        fill <= fill - (PW + 1)'(1);
      end
    end
  end

  // Transmit sequencer: word, then an inter-word null gap
  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic [4:0] tx_idx;
  logic [1:0] tx_gap;
  word_t tx_shift;
  wire gap_last = tx_gap == 2'(`TX_GAP_BITS - 1);
  wire word_last = tx_idx == 5'(`WORD_BITS - 1);
  wire tx_start_ok = go_s & ~fifo_empty;
  assign tx_load = bit_tick && tx_start_ok &&
                   (tx_state == TX_IDLE || (tx_state == TX_GAP && gap_last));
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (tx_load) begin
          next_tx_state = TX_SEND;
        end
      end
      TX_SEND: begin
        if (bit_tick && word_last) begin
          next_tx_state = TX_GAP;
        end
      end
      TX_GAP: begin
        if (bit_tick && gap_last) begin
          next_tx_state = tx_load ? TX_SEND : TX_IDLE;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  // Sequencer registers; bit 1 goes out first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_state <= TX_IDLE;
      tx_shift <= '0;
      tx_idx <= 5'h00;
      tx_gap <= 2'h0;
    end else begin
      tx_state <= next_tx_state;
      if (tx_load) begin
        tx_shift <= fifo_mem[rd_ptr];
        tx_idx <= 5'h00;
      end else if (tx_state == TX_SEND && bit_tick) begin
        tx_shift <= tx_shift >> 1;
        tx_idx <= tx_idx + 5'h01;
      end
      if (tx_state != TX_GAP) begin
        tx_gap <= 2'h0;
      end else if (bit_tick) begin
        tx_gap <= tx_gap + 2'h1;
      end
    end
  end

  // Line outputs: half-bit pulse on one wire, null for the rest
  wire sending = tx_state == TX_SEND;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ones_line_out <= 1'b0;
      zeros_line_out <= 1'b0;
    end else begin
      ones_line_out <= sending & tx_shift[0] & tx_first_half;
      zeros_line_out <= sending & ~tx_shift[0] & tx_first_half;
    end
  end

  // Ready flag high only with FIFO drained and line idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xmit_ready_flag <= 1'b1;
    end else begin
      xmit_ready_flag <= fifo_empty & ~push & (next_tx_state == TX_IDLE);
    end
  end
endmodule : avio_port

/* File: rtl/avio_defines.svh */
// Constants for the avionics serial port: control word fields and timing.
// Assumes inclusion by bare name from the design files only.
`ifndef AVIO_DEFINES_SVH
`define AVIO_DEFINES_SVH
// Control word field positions on the parallel bus
`define CTRL_PAR_EN 4
`define CTRL_SELF_TEST_N 5
`define CTRL_DEC1_EN 6
`define CTRL_DEC1_B9 7
`define CTRL_DEC1_B10 8
`define CTRL_DEC2_EN 9
`define CTRL_DEC2_B9 10
`define CTRL_DEC2_B10 11
`define CTRL_PAR_EVEN 12
`define CTRL_TX_SLOW 13
`define CTRL_RX_SLOW 14
`define CTRL_MASK 16'h7FF0
`define CTRL_RESET 16'h0020
// Reset value of the pin synchroniser (bus drives and gate idle high)
`define SYNC_RESET 28'h0000610
// Clock rates and dividers
`define CLOCK_KHZ 125000
`define MASTER_KHZ 1000
`define TX_FAST_DIV 10
`define TX_SLOW_DIV 80
`define RX_SLOW_DIV 8
`define SAMPLES_PER_BIT 10
`define RX_MIN_SAMPLES 3
`define RX_MAX_SAMPLES 7
`define RX_GAP_SAMPLES (2 * `SAMPLES_PER_BIT)
`define TX_GAP_BITS 4
`define WORD_BITS 32
`define FIFO_DEPTH 8
`endif

/* File: rtl/avio_pkg.sv */
// Types shared by the avionics serial port files.
// Assumes nothing beyond a SystemVerilog compiler.
package avio_pkg;
  typedef logic [15:0] half_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {LINE_NULL, LINE_ONE, LINE_ZERO} line_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} tx_state_t;
endpackage : avio_pkg

/* File: rtl/avio_receiver.sv */
// One serial receiver: bit recovery, parity result, label filter, ready flag.
// Assumes line levels already synchronised and a sample tick of 10 per bit.
`timescale 1ns/1ns
`include "avio_defines.svh"
module avio_receiver (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Sampling and line levels
  input wire logic sample_tick,
  input wire logic line_one,
  input wire logic line_zero,
  // Label filter
  input wire logic decoder_on,
  input wire logic match_b9,
  input wire logic match_b10,
  // Host side
  input wire logic read_low_done,
  input wire logic read_high_done,
  output avio_pkg::word_t word,
  output logic ready_n
);
  import avio_pkg::*;
  line_t level;
  line_t held;
  logic [4:0] run_len;
  logic [5:0] bit_count;
  word_t shift;
  word_t next_shift;
  logic ready;
  logic got_low;
  logic got_high;
  // Line decode and bit qualification by pulse length in samples
  assign level = (line_one & ~line_zero) ? LINE_ONE :
                 (line_zero & ~line_one) ? LINE_ZERO : LINE_NULL;
  wire bit_end = sample_tick && level != held && held != LINE_NULL;
  wire bit_ok = run_len >= 5'(`RX_MIN_SAMPLES) && run_len <= 5'(`RX_MAX_SAMPLES);
  wire gap_seen = sample_tick && held == LINE_NULL && run_len >= 5'(`RX_GAP_SAMPLES);
  wire take_bit = bit_end && bit_ok;
  assign next_shift = {held == LINE_ONE, shift[31:1]};
  wire word_complete_pulse = take_bit && bit_count == 6'(`WORD_BITS - 1);
  wire label_ok = !decoder_on || (next_shift[8] == match_b9 && next_shift[9] == match_b10);
  wire accept = word_complete_pulse && label_ok;
  wire both_read = (got_low | read_low_done) && (got_high | read_high_done);
  assign ready_n = ~ready;
  // Run length of the current line level, saturating
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      held <= LINE_NULL;
      run_len <= 5'h00;
    end else if (sample_tick) begin
      if (level != held) begin
        held <= level;
        run_len <= 5'h01;
      end else if (run_len != 5'h1F) begin
        run_len <= run_len + 5'h01;
      end
    end
  end
  // Bit count; a long null or a malformed pulse restarts the word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_count <= 6'h00;
      shift <= '0;
    end else begin
      if (gap_seen || (bit_end && !bit_ok) || word_complete_pulse) begin
        bit_count <= 6'h00;
      end else if (take_bit) begin
        bit_count <= bit_count + 6'h01;
      end
      if (take_bit) begin
        shift <= next_shift;
      end
    end
  end
  // Stored word and ready flag; a new word beats a read in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word <= '0;
      ready <= 1'b0;
      got_low <= 1'b0;
      got_high <= 1'b0;
    end else if (accept) begin
      word <= {~^next_shift, next_shift[30:0]};
      ready <= 1'b1;
      got_low <= 1'b0;
      got_high <= 1'b0;
    end else if (ready && both_read) begin
      ready <= 1'b0;
      got_low <= 1'b0;
      got_high <= 1'b0;
    end else if (ready) begin
      got_low <= got_low | read_low_done;
      got_high <= got_high | read_high_done;
    end
  end
endmodule : avio_receiver

/* File: verif/avio_port_checker.sv */
// Port checker: host bus drive, ready flags and transmit line relations.
// Assumes a bind into avio_port; host pins change away from the rising edge.
`timescale 1ns/1ns
module avio_port_checker #(
  parameter int MASTER_DIV = 1,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Host bus side
  input wire avio_pkg::half_t parallel_bus_bit_out,
  input wire logic parallel_bus_bit_oe,
  input wire logic rx_one_bus_drive,
  input wire logic rx_two_bus_drive,
  input wire logic rx_one_ready_n,
  // Transmitter side
  input wire logic tx_high_half_latch,
  input wire logic xmit_ready_flag,
  input wire logic ones_line_out,
  input wire logic zeros_line_out
);
  import avio_pkg::*;

  // One clock domain, all checks off during reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Bus released once both enables have been idle past the synchroniser
  property p_idle_release;
    (rx_one_bus_drive && rx_two_bus_drive) [*6] |-> !parallel_bus_bit_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("bus driven with no read enable");

  // Undriven bus carries zero so no stale data leaks
  property p_zero_out;
    !parallel_bus_bit_oe |-> parallel_bus_bit_out == 16'h0000;
  endproperty
  a_zero_out: assert property (p_zero_out)
    else $error("bus data not zero while released");

  // Receiver one read drives the bus
  property p_rx_one;
    (!rx_one_bus_drive) [*6] |-> parallel_bus_bit_oe;
  endproperty
  a_rx_one: assert property (p_rx_one)
    else $error("receiver one read did not drive bus");

  // Receiver two read drives the bus when receiver one is idle
  property p_rx_two;
    (rx_one_bus_drive && !rx_two_bus_drive) [*6] |-> parallel_bus_bit_oe;
  endproperty
  a_rx_two: assert property (p_rx_two)
    else $error("receiver two read did not drive bus");

  // Ready flag only releases a few clocks after a finished read
  property p_ready_release;
    $rose(rx_one_ready_n) |-> $past(rx_one_bus_drive, 2) && !$past(rx_one_bus_drive, 8);
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("receiver one ready released without a read");

  // Transmit ready only drops after a second-half latch (pin, sync, push, flag)
  property p_load_flag;
    $fell(xmit_ready_flag) |-> $past(tx_high_half_latch, 3);
  endproperty
  a_load_flag: assert property (p_load_flag)
    else $error("transmit ready dropped without a load");

  // Ones and zeros never pulse together
  property p_line_excl;
    !(ones_line_out && zeros_line_out);
  endproperty
  a_line_excl: assert property (p_line_excl)
    else $error("ones and zeros outputs both high");

  // A ones pulse lasts at least five clocks, half of the fastest bit only when MASTER_DIV is 1
  property p_pulse;
    $rose(ones_line_out) |-> ones_line_out [*5];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ones pulse too short");

  // Lines stay null while the transmitter reports ready
  property p_idle_lines;
    xmit_ready_flag |-> !ones_line_out && !zeros_line_out;
  endproperty
  a_idle_lines: assert property (p_idle_lines)
    else $error("line pulse while transmitter ready");
endmodule : avio_port_checker

bind avio_port avio_port_checker #(.MASTER_DIV(MASTER_DIV), .FIFO_DEPTH(FIFO_DEPTH)) u_check (
  .clock(clock),
  .rstn(rstn),
  .parallel_bus_bit_out(parallel_bus_bit_out),
  .parallel_bus_bit_oe(parallel_bus_bit_oe),
  .rx_one_bus_drive(rx_one_bus_drive),
  .rx_two_bus_drive(rx_two_bus_drive),
  .rx_one_ready_n(rx_one_ready_n),
  .tx_high_half_latch(tx_high_half_latch),
  .xmit_ready_flag(xmit_ready_flag),
  .ones_line_out(ones_line_out),
  .zeros_line_out(zeros_line_out)
);

/* File: verif/avio_host.sv */
// Host processor model: strobes, read enables and bus data for the port.
// Assumes the bench resolves the bus wire and calls these tasks.
`timescale 1ns/1ns
module avio_host (
  // Clock
  input wire logic clock,
  // Resolved bus wire
  input wire avio_pkg::half_t bus_wire,
  // Host drive
  output avio_pkg::half_t host_data,
  output logic cfg_stb,
  output logic low_stb,
  output logic high_stb,
  output logic sel,
  output logic en1,
  output logic en2,
  output logic go
);
  import avio_pkg::*;

  // Idle host: no strobes, no reads
  initial begin
    host_data = 16'h0000;
    cfg_stb = 1'b0;
    low_stb = 1'b0;
    high_stb = 1'b0;
    sel = 1'b0;
    en1 = 1'b1;
    en2 = 1'b1;
    go = 1'b0;
  end

  // Strobe with data set early and held past the synchroniser
  task automatic strobe(input int which, input half_t d);
    @(negedge clock);
    host_data = d;
    @(negedge clock);
    if (which == 0) low_stb = 1'b1;
    else if (which == 1) high_stb = 1'b1;
    else cfg_stb = 1'b1;
    repeat (6) @(negedge clock);
    low_stb = 1'b0;
    high_stb = 1'b0;
    cfg_stb = 1'b0;
    repeat (4) @(negedge clock);
    host_data = ~d; // Released bus must not look like the old value
    repeat (2) @(negedge clock);
  endtask : strobe

  // Word load: first half always before second half
  task automatic load(input half_t h1, input half_t h2);
    strobe(0, h1);
    strobe(1, h2);
  endtask : load

  // Half read: chooser held until well after the enable rises
  task automatic read(input logic two, input logic half, output half_t d);
    @(negedge clock);
    sel = half;
    if (two) en2 = 1'b0;
    else en1 = 1'b0;
    repeat (8) @(negedge clock);
    d = bus_wire;
    en1 = 1'b1;
    en2 = 1'b1;
    repeat (6) @(negedge clock);
  endtask : read

  task automatic set_go(input logic v);
    @(negedge clock);
    go = v;
  endtask : set_go
endmodule : avio_host

/* File: verif/avio_port_tb.sv */
// Self-checking bench: port in self-test or pin loopback, host model on the bus.
// Assumes the checker is bound in; master tick of one fast clock for speed.
`timescale 1ns/1ns
module avio_port_tb;
  import avio_pkg::*;
  localparam int MDIV = 1;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic gate_n = 1'b1;
  half_t host_data, bus_out, bus_wire;
  logic oe, sel, en1, en2, lo, hi, cfg, go;
  logic rdy1, rdy2, xrdy, ones, zeros, txclk;
  int fail_count = 0;
  int num_checks = 0;
  wire logic [2:0] flags = {xrdy, rdy2, rdy1};

  // Bus wire: device wins only while it drives
  assign bus_wire = oe ? bus_out : host_data;
  always #4 clock = ~clock;

  avio_host host (.clock(clock), .bus_wire(bus_wire), .host_data(host_data),
    .cfg_stb(cfg), .low_stb(lo), .high_stb(hi), .sel(sel), .en1(en1), .en2(en2), .go(go));

  // Receiver one pins looped from the line outputs; receiver two pins held null
  avio_port #(.MASTER_DIV(MDIV)) DUT (.clock(clock), .rstn(rstn),
    .rx_one_line_in({ones, zeros}), .rx_two_line_in(2'b00),
    .parallel_bus_bit_in(bus_wire), .parallel_bus_bit_out(bus_out),
    .parallel_bus_bit_oe(oe), .half_word_chooser(sel), .rx_one_bus_drive(en1),
    .rx_two_bus_drive(en2), .rx_one_ready_n(rdy1), .rx_two_ready_n(rdy2),
    .tx_low_half_latch(lo), .tx_high_half_latch(hi), .config_word_strobe(cfg),
    .xmit_go(go), .bit_control_gate_n(gate_n), .xmit_ready_flag(xrdy),
    .ones_line_out(ones), .zeros_line_out(zeros), .tx_clock_out(txclk));

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait on one flag; a timeout ends the run
  task automatic wait_sig(input int idx, input logic lvl, input int lim);
    int n;
    n = 0;
    while (flags[idx] !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, flags[idx], lvl);
      test_done;
    end
  endtask : wait_sig

  // Rising edges of the bit clock in a fixed window
  task automatic tx_period(input int per);
    int n;
    logic p;
    n = 0;
    repeat (100) @(negedge clock);
    p = txclk;
    repeat (800) begin
      @(negedge clock);
      if (txclk && !p) n++;
      p = txclk;
    end
    check(n, 800 / (per * MDIV));
  endtask : tx_period

  task automatic sc_reset;
    repeat (10) @(negedge clock);
    check(flags, 3'b111);
    check({oe, ones, zeros, txclk}, 4'h0);
    rstn = 1'b1;
    host.load(16'h1234, 16'h5678);
    check(xrdy, 1'b0);
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    check(flags, 3'b111);
    rstn = 1'b1;
  endtask : sc_reset

  // One word around the loopback, then read back through receiver one, and through receiver two when pass2 is set
  task automatic sc_loop(input half_t ctrl, input logic gate, input half_t h1, input half_t h2,
                         input logic pass2, input logic b32, input int per);
    half_t d;
    gate_n = gate;
    host.strobe(2, ctrl);
    tx_period(per);
    host.load(h1, h2);
    check({xrdy, ones, zeros}, 3'b000);
    host.set_go(1'b1);
    wait_sig(0, 1'b0, 4000);
    host.read(1'b0, 1'b0, d);
    check(d, {h1[15:9], b32, h1[7:0]});
    check(rdy1, 1'b0);
    host.read(1'b0, 1'b1, d);
    check(d, h2);
    check(flags[1:0], {~pass2, 1'b1});
    if (pass2) begin
      host.read(1'b1, 1'b1, d);
      check(d, h2);
      host.read(1'b1, 1'b0, d);
      check(d, {h1[15:9], b32, h1[7:0]});
    end
    wait_sig(2, 1'b1, 1000);
    check(flags, 3'b111);
    host.set_go(1'b0);
  endtask : sc_loop

  // Nine loads with sending held off; eight come out in order
  task automatic sc_fifo;
    half_t d;
    gate_n = 1'b1;
    host.strobe(2, 16'h0010);
    for (int i = 0; i < 9; i++) begin
      host.load({4'(i), 12'hA55}, {12'h3C5, 4'(i)});
    end
    check({xrdy, rdy1, ones, zeros}, 4'b0100);
    host.set_go(1'b1);
    for (int i = 0; i < 8; i++) begin
      wait_sig(0, 1'b0, 1000);
      host.read(1'b0, 1'b0, d);
      check(d, {4'(i), 12'hA55});
      host.read(1'b0, 1'b1, d);
      check(d, {12'h3C5, 4'(i)});
    end
    wait_sig(2, 1'b1, 1000);
    check({rdy1, rdy2}, 2'b10);
    host.read(1'b1, 1'b0, d);
    check(d, 16'h7A55);
    host.set_go(1'b0);
  endtask : sc_fifo

  // Main sequence: odd, even, label filter, gate low, pin path, slow rates, queue
  initial begin
    sc_reset;
    sc_loop(16'h0010, 1'b1, 16'h0853, 16'hC3A5, 1'b1, 1'b0, 10);
    sc_loop(16'h1010, 1'b1, 16'h0952, 16'h3C5A, 1'b1, 1'b1, 10);
    sc_loop(16'h0AD0, 1'b1, 16'h0853, 16'h0F0F, 1'b0, 1'b0, 10);
    sc_loop(16'h0010, 1'b0, 16'h0953, 16'h0003, 1'b1, 1'b1, 10);
    sc_loop(16'h0030, 1'b1, 16'h0853, 16'h5A5A, 1'b0, 1'b0, 10);
    sc_loop(16'h6010, 1'b1, 16'h0853, 16'hA5A5, 1'b1, 1'b0, 80);
    sc_fifo;
    test_done;
  end
endmodule : avio_port_tb
